// file: rps_pkg.sv
// Purpose: Shared constants and types for the RAM profile sequencer
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes:   Profile words are held as two registers per profile
package rps_pkg;

  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned RAM_AW   = 10;
  localparam int unsigned RATE_W   = 16;
  localparam int unsigned NPROF    = 8;
  localparam int unsigned PIDX_W   = 3;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_PROF_LO  = 8'h40;
  localparam logic [7:0] REG_PROF_HI  = 8'h44;
  localparam logic [7:0] PROF_STRIDE  = 8'h08;

  // First control register fields
  localparam int unsigned SEQ_LSB  = 17;
  localparam int unsigned SEQ_MSB  = 20;
  localparam int unsigned DEST_LSB = 29;
  localparam int unsigned DEST_MSB = 30;

  // Profile low word: start and end address
  localparam int unsigned START_LSB = 0;
  localparam int unsigned END_LSB   = 16;
  // Profile high word: step interval, mode bits, no-dwell bit (stored only)
  localparam int unsigned RATE_LSB  = 0;

  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] PROF_RST  = 32'h0000_0000;

  localparam logic [3:0] SEQ_OFF     = 4'h0;
  localparam logic [3:0] SEQ_INVALID = 4'hF;

  localparam logic [1:0] DONE_CYCLES = 2'h2;

  // Interrupt bits
  localparam int unsigned INT_DONE = 0;
  localparam int unsigned INT_HALT = 1;
  localparam int unsigned INT_W    = 2;

  typedef enum logic [3:0] {
    SEQ_IDLE  = 4'h1,
    SEQ_RUN   = 4'h2,
    SEQ_DWELL = 4'h4,
    SEQ_HALT  = 4'h8
  } rps_state_e;

endpackage : rps_pkg

// Purpose: Address step interval timer
// Assumes: Interval of zero behaves as one cycle
// Notes:   Restart takes priority over counting
`timescale 1ns/100ps
`default_nettype none
module rps_step_timer #(
  parameter int unsigned RATE_W = 16
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Control
  input  wire logic              restart_i,
  input  wire logic              run_i,
  input  wire logic [RATE_W-1:0] interval_i,
  // Event
  output logic                   expire_o
);

  typedef struct packed {
    logic [RATE_W-1:0] cnt;
  } rps_tmr_s;

  rps_tmr_s tmr_q;
  rps_tmr_s tmr_d;

  always_comb begin
    tmr_d    = tmr_q;
    // Expiry looks at the count, run_i and interval_i only, so a restart derived from it cannot form a loop
    expire_o = run_i && ((tmr_q.cnt + RATE_W'(1)) >= interval_i);
    if (restart_i || !run_i || expire_o) begin
      tmr_d.cnt = '0;
    end else begin
      tmr_d.cnt = tmr_q.cnt + RATE_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d;
    end
  end

endmodule // rps_step_timer
`default_nettype wire

// file: rps_sequencer.sv
// Purpose: RAM internal profile sequencer with register port and interrupt
// Assumes: One clock at 20 MHz; host drives a plain strobe register port
// Notes:   Control and profile writes land in staging copies; the I/O update strobe makes them active
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Sequencing starts only from the four-bit sequencing field.
// - Nonzero field: profile mode bits are disregarded.
// - No-dwell bit ignored; behaves as ramp-up with internal profile changes.
// - Profile select pins ignored while sequencing is active.
// - Update loading a nonzero field other than 1111 clears sweep-done, loads profile 0 start.
// - Address steps by one per expiry of that profile's own interval.
// - Reaching end address pulses sweep-done high for two clocks.
// - Next expiry after non-final end moves to next profile start and interval.
// - Profiles advance upward until the field's last profile is done.
// - Burst: expiry after final end halts; address then stays.
// - Continuous: expiry after final end returns to profile 0 start.
// - Behaviour changes only after reprogramming plus an update strobe.
// - Any start/end pair per profile accepted, no ordering checks.
// - Code 0010 plays profiles 0..2 then halts; 1000 cycles 0 and 1.
// - Field at bits 20:17; burst, continuous and invalid code decoding.
// - RAM word goes to the destination chosen by the destination field.
module rps_sequencer #(
  parameter int unsigned NPROF  = rps_pkg::NPROF,
  parameter int unsigned RATE_W = rps_pkg::RATE_W
) (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_b_i,
  // Register port
  input  wire logic [rps_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [rps_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_we_i,
  input  wire logic                       reg_re_i,
  output logic      [rps_pkg::DATA_W-1:0] reg_rdata_o,
  // Device pins
  input  wire logic                       io_update_i,
  input  wire logic [rps_pkg::PIDX_W-1:0] profile_i,
  output logic                            sweep_done_out_o,
  output logic                            irq_o,
  // RAM read side and DDS parameter delivery
  output logic      [rps_pkg::RAM_AW-1:0] ram_addr_o,
  input  wire logic [rps_pkg::DATA_W-1:0] ram_rdata_i,
  output logic      [rps_pkg::DATA_W-1:0] dds_word_o,
  output logic                      [1:0] dds_dest_o
);

  localparam int unsigned DW = rps_pkg::DATA_W;
  localparam int unsigned AW = rps_pkg::RAM_AW;
  localparam int unsigned PW = rps_pkg::PIDX_W;
  localparam int unsigned IW = rps_pkg::INT_W;

  typedef struct packed {
    logic [DW-1:0]            ctrl_stage;
    logic [DW-1:0]            ctrl_act;
    logic [NPROF-1:0][DW-1:0] lo_stage;
    logic [NPROF-1:0][DW-1:0] lo_act;
    logic [NPROF-1:0][DW-1:0] hi_stage;
    logic [NPROF-1:0][DW-1:0] hi_act;
    logic [2:0]               upd_sync;
    logic [1:0][PW-1:0]       pin_sync;
    rps_pkg::rps_state_e      state;
    logic [PW-1:0]            pidx;
    logic [AW-1:0]            addr;
    logic [1:0]               done_cnt;
    logic [IW-1:0]            int_stat;
    logic [IW-1:0]            int_mask;
    logic [DW-1:0]            rdata;
    logic [DW-1:0]            dds_word;
    logic [1:0]               dds_dest;
  } rps_state_s;

  rps_state_s st_q;
  rps_state_s st_d;

  logic       rst_meta_q;
  logic       rst_sync_q;
  logic       tmr_restart;
  logic       tmr_expire;
  logic [RATE_W-1:0] cur_rate;

  // Decode of the sequencing code: {enable, continuous, last profile}
  function automatic logic [4:0] seq_decode(input logic [3:0] code);
    logic [4:0] r;
    r = '0;
    if (code != rps_pkg::SEQ_OFF && code != rps_pkg::SEQ_INVALID) begin
      r[4] = 1'b1;
      r[3] = code[3];
      // Continuous codes start at 1000, so their last profile is the code minus seven
      // last profile select
      r[2:0] = code[3] ? (code[2:0] + 3'h1) : code[2:0];
    end
    return r;
  endfunction

  function automatic logic [AW-1:0] start_of(input logic [DW-1:0] lo);
    return lo[rps_pkg::START_LSB +: AW];
  endfunction

  function automatic logic [AW-1:0] end_of(input logic [DW-1:0] lo);
    return lo[rps_pkg::END_LSB +: AW];
  endfunction

  // Register-port profile index for a given base, or NPROF when no match
  function automatic logic [PW:0] prof_hit(input logic [7:0] a, input logic [7:0] base);
    logic [PW:0] r;
    r = (PW+1)'(NPROF);
    for (int i = 0; i < NPROF; i++) begin
      if (a == base + 8'(i) * rps_pkg::PROF_STRIDE) begin
        r = (PW+1)'(i);
      end
    end
    return r;
  endfunction

  // True when a profile lookup found a register
  function automatic logic hit_ok(input logic [PW:0] h);
    return h < (PW+1)'(NPROF);
  endfunction

  // Reset release through two flip-flops
  // Asynchronous assert, synchronous release, so all flops leave reset on one edge
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // A newly loaded profile's interval applies from the cycle after its load
  assign cur_rate = st_q.hi_act[st_q.pidx][rps_pkg::RATE_LSB +: RATE_W];

  // Timer idles outside RUN and DWELL, so a halted burst draws no expiries
  rps_step_timer #(
    .RATE_W (RATE_W)
  ) u_timer (
    .clk_i      (ref_clk_i),
    .rst_b_i    (rst_sync_q),
    .restart_i  (tmr_restart),
    .run_i      (st_q.state == rps_pkg::SEQ_RUN || st_q.state == rps_pkg::SEQ_DWELL),
    .interval_i (cur_rate),
    .expire_o   (tmr_expire)
  );

  always_comb begin
    logic [PW:0]   lo_hit;
    logic [PW:0]   hi_hit;
    logic          upd;
    logic [4:0]    dec;
    logic [PW-1:0] nxt;
    logic          load;
    logic          ev_done;
    logic          ev_halt;
    lo_hit      = prof_hit(reg_addr_i, rps_pkg::REG_PROF_LO);
    hi_hit      = prof_hit(reg_addr_i, rps_pkg::REG_PROF_HI);
    upd         = 1'b0;
    dec         = '0;
    nxt         = '0;
    load        = 1'b0;
    ev_done     = 1'b0;
    ev_halt     = 1'b0;
    st_d        = st_q;
    tmr_restart = 1'b0;

    // Pin synchronisers; only the second stage and later are looked at
    // The third update stage exists only for the rising-edge detect
    st_d.upd_sync = {st_q.upd_sync[1:0], io_update_i};
    st_d.pin_sync = {st_q.pin_sync[0], profile_i};
    upd = st_q.upd_sync[1] && !st_q.upd_sync[2];

    // Register writes go to staging or control state
    if (reg_we_i) begin
      if (reg_addr_i == rps_pkg::REG_CTRL) begin
        st_d.ctrl_stage = reg_wdata_i;
      end
      if (reg_addr_i == rps_pkg::REG_INT_STAT) begin
        st_d.int_stat = st_q.int_stat & ~reg_wdata_i[IW-1:0];
      end
      if (reg_addr_i == rps_pkg::REG_INT_MASK) begin
        st_d.int_mask = reg_wdata_i[IW-1:0];
      end
      if (hit_ok(lo_hit)) begin
        st_d.lo_stage[lo_hit[PW-1:0]] = reg_wdata_i;
      end
      if (hit_ok(hi_hit)) begin
        st_d.hi_stage[hi_hit[PW-1:0]] = reg_wdata_i;
      end
    end

    // Read data appears the cycle after the read strobe
    st_d.rdata = '0;
    if (reg_re_i) begin
      if (reg_addr_i == rps_pkg::REG_CTRL) begin
        st_d.rdata = st_q.ctrl_stage;
      end else if (reg_addr_i == rps_pkg::REG_STATUS) begin
        // Layout: state 22:19, profile 18:16, sweep-done 15, address 9:0
        st_d.rdata = DW'({st_q.state, st_q.pidx, sweep_done_out_o, 5'h00, st_q.addr});
      end else if (reg_addr_i == rps_pkg::REG_INT_STAT) begin
        st_d.rdata = DW'(st_q.int_stat);
      end else if (reg_addr_i == rps_pkg::REG_INT_MASK) begin
        st_d.rdata = DW'(st_q.int_mask);
      end else if (hit_ok(lo_hit)) begin
        st_d.rdata = st_q.lo_stage[lo_hit[PW-1:0]];
      end else if (hit_ok(hi_hit)) begin
        st_d.rdata = st_q.hi_stage[hi_hit[PW-1:0]];
      end
    end

    if (st_q.done_cnt != 2'h0) begin
      st_d.done_cnt = st_q.done_cnt - 2'h1;
    end

    dec = seq_decode(st_q.ctrl_act[rps_pkg::SEQ_MSB:rps_pkg::SEQ_LSB]);

    if (upd) begin
      st_d.ctrl_act = st_q.ctrl_stage;
      st_d.lo_act   = st_q.lo_stage;
      st_d.hi_act   = st_q.hi_stage;
      dec = seq_decode(st_q.ctrl_stage[rps_pkg::SEQ_MSB:rps_pkg::SEQ_LSB]);
      if (dec[4]) begin
        st_d.done_cnt = 2'h0;
        st_d.pidx     = '0;
        load          = 1'b1;
      end else begin
        // Code off or invalid: the pins own the address from the next cycle
        st_d.state = rps_pkg::SEQ_IDLE;
      end
    end else begin
      case (st_q.state)
        rps_pkg::SEQ_IDLE: begin
          // Without sequencing the pins pick the profile
          st_d.addr = start_of(st_q.lo_act[st_q.pin_sync[1]]);
        end
        rps_pkg::SEQ_RUN: begin
          if (tmr_expire) begin
            st_d.addr = st_q.addr + AW'(1);
            // Compare the new address so the pulse starts as the end address appears
            if (st_d.addr == end_of(st_q.lo_act[st_q.pidx])) begin
              st_d.state = rps_pkg::SEQ_DWELL;
              ev_done    = 1'b1;
            end
          end
        end
        rps_pkg::SEQ_DWELL: begin
          if (tmr_expire) begin
            if (st_q.pidx == dec[2:0]) begin
              if (dec[3]) begin
                st_d.pidx = '0;
                load      = 1'b1;
              end else begin
                st_d.state = rps_pkg::SEQ_HALT;
                ev_halt    = 1'b1;
              end
            end else begin
              nxt       = st_q.pidx + PW'(1);
              st_d.pidx = nxt;
              load      = 1'b1;
            end
          end
        end
        rps_pkg::SEQ_HALT: begin
          // Address and profile index hold until the next update
          st_d.state = rps_pkg::SEQ_HALT;
        end
        default: begin
          st_d.state = rps_pkg::SEQ_IDLE;
        end
      endcase
    end

    // Mode and no-dwell bits of the high words are stored and read back only
    // mode bits unused
    if (load) begin
      tmr_restart = 1'b1;
      st_d.addr   = start_of(st_d.lo_act[st_d.pidx]);
      // A single-address profile is at its end already, so it pulses at load
      if (st_d.addr == end_of(st_d.lo_act[st_d.pidx])) begin
        st_d.state = rps_pkg::SEQ_DWELL;
        ev_done    = 1'b1;
      end else begin
        st_d.state = rps_pkg::SEQ_RUN;
      end
    end

    if (ev_done) begin
      st_d.done_cnt = rps_pkg::DONE_CYCLES;
    end

    // Event set wins over a same-cycle software clear
    if (ev_done) begin
      st_d.int_stat[rps_pkg::INT_DONE] = 1'b1;
    end
    if (ev_halt) begin
      st_d.int_stat[rps_pkg::INT_HALT] = 1'b1;
    end

    // One register stage on the RAM word; destination follows the active control copy
    // route RAM word
    st_d.dds_word = ram_rdata_i;
    st_d.dds_dest = st_q.ctrl_act[rps_pkg::DEST_MSB:rps_pkg::DEST_LSB];
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st_q            <= '0;
      st_q.ctrl_stage <= rps_pkg::CTRL_RST;
      st_q.ctrl_act   <= rps_pkg::CTRL_RST;
      st_q.lo_stage   <= {NPROF{rps_pkg::PROF_RST}};
      st_q.lo_act     <= {NPROF{rps_pkg::PROF_RST}};
      st_q.hi_stage   <= {NPROF{rps_pkg::PROF_RST}};
      st_q.hi_act     <= {NPROF{rps_pkg::PROF_RST}};
      st_q.state      <= rps_pkg::SEQ_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o      = st_q.rdata;
  assign sweep_done_out_o = (st_q.done_cnt != 2'h0);
  assign irq_o            = |(st_q.int_stat & st_q.int_mask);
  assign ram_addr_o       = st_q.addr;
  assign dds_word_o       = st_q.dds_word;
  assign dds_dest_o       = st_q.dds_dest;

endmodule // rps_sequencer
`default_nettype wire

// file: rps_sequencer_asserts.sv
// Purpose: Port-level checks for the RAM profile sequencer
// Assumes: Bound to rps_sequencer; one clock domain
// Notes:   Sees only the top module's ports
`timescale 1ns/100ps
`default_nettype none
module rps_sequencer_asserts (
  input wire logic                       ref_clk_i,
  input wire logic                       rst_b_i,
  input wire logic [rps_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic                       reg_re_i,
  input wire logic [rps_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic                       io_update_i,
  input wire logic                       sweep_done_out_o,
  input wire logic [rps_pkg::RAM_AW-1:0] ram_addr_o,
  input wire logic [rps_pkg::DATA_W-1:0] ram_rdata_i,
  input wire logic [rps_pkg::DATA_W-1:0] dds_word_o
);
  // Design leaves reset two edges after the pin, so wait before pipeline checks
  logic [2:0] live_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      live_q <= 3'h0;
    end else if (live_q != 3'h7) begin
      live_q <= live_q + 3'h1;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_done_two; $rose(sweep_done_out_o) |=> sweep_done_out_o ##1 !sweep_done_out_o; endproperty
  a_done_two: assert property (p_done_two)
    else $error("sweep-done pulse longer or shorter than two cycles");
  property p_done_fall; $fell(sweep_done_out_o) |-> $past(sweep_done_out_o, 2); endproperty
  a_done_fall: assert property (p_done_fall)
    else $error("sweep-done fell after one cycle");
  property p_upd_clr; $rose(io_update_i) |-> ##[2:4] !sweep_done_out_o; endproperty
  a_upd_clr: assert property (p_upd_clr)
    else $error("sweep-done not cleared by update");
  property p_dds_word; live_q == 3'h7 |-> dds_word_o == $past(ram_rdata_i); endproperty
  a_dds_word: assert property (p_dds_word)
    else $error("RAM word not delivered one cycle later");
  property p_rd_idle; live_q == 3'h7 && !$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the answer cycle");
  property p_unmapped; reg_re_i && reg_addr_i == 8'h10 |=> reg_rdata_o == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_stat_addr; reg_re_i && reg_addr_i == rps_pkg::REG_STATUS |=> reg_rdata_o[9:0] == $past(ram_addr_o);
  endproperty
  a_stat_addr: assert property (p_stat_addr)
    else $error("status address differs from RAM address");
  property p_stat_done; reg_re_i && reg_addr_i == rps_pkg::REG_STATUS |=> reg_rdata_o[15] == $past(sweep_done_out_o);
  endproperty
  a_stat_done: assert property (p_stat_done)
    else $error("status sweep-done differs from pin");
endmodule // rps_sequencer_asserts
bind rps_sequencer rps_sequencer_asserts i_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .io_update_i(io_update_i),
  .sweep_done_out_o(sweep_done_out_o), .ram_addr_o(ram_addr_o), .ram_rdata_i(ram_rdata_i),
  .dds_word_o(dds_word_o));
`default_nettype wire

// file: rps_ram_model.sv
// Purpose: Waveform RAM seen by the sequencer
// Assumes: Combinational read in the sequencer's clock domain
// Notes:   Contents derived from the address, no load path
`timescale 1ns/100ps
`default_nettype none
module rps_ram_model (
  input  wire logic [rps_pkg::RAM_AW-1:0] ram_addr_i,
  output logic      [rps_pkg::DATA_W-1:0] ram_rdata_o
);
  // word per address
  // Both polarities of the address, so a stale or shifted word cannot match
  assign ram_rdata_o = {12'hA5C, ram_addr_i, ~ram_addr_i};
endmodule // rps_ram_model
`default_nettype wire

// file: rps_sequencer_tb_top.sv
// Purpose: Self-checking bench for the RAM profile sequencer
// Assumes: 20 MHz clock; profile pins toggle at random throughout
// Notes:   Expected end addresses and reads queue up; a monitor pops them
`timescale 1ns/100ps
`default_nettype none
module rps_sequencer_tb_top;
  logic        ref_clk_i, rst_b_i, reg_we_i, reg_re_i, io_update_i, sweep_done_out_o, irq_o;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, ram_rdata_i, dds_word_o, rnd;
  logic [2:0]  profile_i;
  logic [9:0]  ram_addr_o;
  logic [1:0]  dds_dest_o;
  logic [63:0] q_rd[$];
  logic [63:0] note;
  logic [9:0]  q_end[$];
  logic        rd_seen = 1'b0, sw_prev = 1'b0;
  int          fails, samples_checked, cyc, last;
  integer      seed = 23845;

  rps_sequencer i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .io_update_i(io_update_i), .profile_i(profile_i), .sweep_done_out_o(sweep_done_out_o), .irq_o(irq_o),
    .ram_addr_o(ram_addr_o), .ram_rdata_i(ram_rdata_i), .dds_word_o(dds_word_o), .dds_dest_o(dds_dest_o));
  rps_ram_model i_ram (.ram_addr_i(ram_addr_o), .ram_rdata_o(ram_rdata_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task end_sim;
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_we_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    q_rd.push_back({m, e});
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_re_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic set_prof(input logic [2:0] i, input logic [9:0] s, input logic [9:0] e, input logic [15:0] t);
    logic [31:0] mode_bits;
    wr(rps_pkg::REG_PROF_LO + {2'h0, i, 3'h0}, {6'h00, e, 6'h00, s});
    // Mode and no-dwell bits random: they must not matter
    mode_bits = $random(seed);
    wr(rps_pkg::REG_PROF_HI + {2'h0, i, 3'h0}, {mode_bits[31:16], t});
  endtask
  task upd;
    io_update_i <= 1'b1;
    @(posedge ref_clk_i);
    io_update_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic wait_q;
    int n;
    n = 0;
    while (q_end.size() != 0 && n < 600) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 600) chk("pulses_missing", 32'h0, 32'(q_end.size()));
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    rnd = $random(seed);
    profile_i <= rnd[2:0];
    if (rd_seen) begin
      if (q_rd.size() == 0) chk("read_notes", 32'h1, 32'h0);
      else begin
        note = q_rd.pop_front();
        chk("reg_rdata_o", note[31:0], reg_rdata_o & note[63:32]);
      end
    end
    if (sweep_done_out_o === 1'b1 && sw_prev !== 1'b1) begin
      if (q_end.size() == 0) chk("extra_pulse", 32'h0, 32'h1);
      else chk("end_address", {22'h0, q_end.pop_front()}, {22'h0, ram_addr_o});
    end
    rd_seen = reg_re_i;
    sw_prev = sweep_done_out_o;
    if (cyc == 40000) begin
      chk("timeout", 32'h0, 32'h1);
      end_sim();
    end
  end

  initial begin
    {rst_b_i, reg_we_i, reg_re_i, io_update_i, reg_addr_i, reg_wdata_i} = '0;
    repeat (4) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(rps_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    // Profile 1 sits below profile 0; profile 2 is a single address
    // Profile 1's dwell must exceed two clocks or its pulse merges with profile 2's
    set_prof(3'h0, 10'h00A, 10'h00C, 16'h0001);
    set_prof(3'h1, 10'h005, 10'h006, 16'h0004);
    set_prof(3'h2, 10'h014, 10'h014, 16'h0003);
    rd(8'h48, 32'hFFFF_FFFF, 32'h0006_0005);
    wr(rps_pkg::REG_INT_MASK, 32'h0000_0003);
    q_end = {10'h00C, 10'h006, 10'h014};
    wr(rps_pkg::REG_CTRL, 32'h4004_0000);
    upd();
    wait_q();
    repeat (20) @(posedge ref_clk_i);
    chk("ram_addr_o", 32'h14, {22'h0, ram_addr_o});
    chk("dds_dest_o", 32'h2, {30'h0, dds_dest_o});
    chk("dds_word_o", {12'hA5C, 10'h014, 10'h3EB}, dds_word_o);
    chk("irq_o", 32'h1, {31'h0, irq_o});
    rd(rps_pkg::REG_STATUS, 32'h007F_83FF, 32'h0042_0014);
    rd(rps_pkg::REG_INT_STAT, 32'h0000_0003, 32'h0000_0003);
    wr(rps_pkg::REG_INT_STAT, 32'h0000_0003);
    chk("irq_o", 32'h0, {31'h0, irq_o});
    // Invalid code must leave the sequencer idle
    wr(rps_pkg::REG_INT_MASK, 32'h0000_0000);
    wr(rps_pkg::REG_CTRL, 32'h001E_0000);
    upd();
    repeat (30) @(posedge ref_clk_i);
    rd(rps_pkg::REG_STATUS, 32'h0078_0000, 32'h0008_0000);
    // Profile 0 is slow so the staged control write lands before profile 0 ends
    for (int i = 0; i < 8; i++) set_prof(3'(i), 10'(100 + 8 * i), 10'(101 + 8 * i), (i == 0) ? 16'hA : 16'(i % 3 + 1));
    for (int c = 1; c < 15; c++) begin
      last = (c < 8) ? c : c - 7;
      for (int p = 0; p <= last; p++) q_end.push_back(10'(101 + 8 * p));
      if (c > 7) q_end.push_back(10'd101);
      wr(rps_pkg::REG_CTRL, 32'(c) << 17);
      upd();
      // Staged only: sequencing must carry on until the next update
      wr(rps_pkg::REG_CTRL, 32'h0000_0000);
      wait_q();
      upd();
      repeat (30) @(posedge ref_clk_i);
    end
    chk("irq_o", 32'h0, {31'h0, irq_o});
    end_sim();
  end
endmodule // rps_sequencer_tb_top
`default_nettype wire
